// ### imf_consts.vh
`ifndef IMF_CONSTS_VH
`define IMF_CONSTS_VH
`define IMF_CLK_NS        10
`define IMF_CAPF1_NS      111
`define IMF_CAPF2_NS      1780
`define IMF_CAPF3_NS      14220
`define IMF_CAPF1_CYC     ((`IMF_CAPF1_NS + `IMF_CLK_NS - 1) / `IMF_CLK_NS)
`define IMF_CAPF2_CYC     ((`IMF_CAPF2_NS + `IMF_CLK_NS - 1) / `IMF_CLK_NS)
`define IMF_CAPF3_CYC     ((`IMF_CAPF3_NS + `IMF_CLK_NS - 1) / `IMF_CLK_NS)
`define IMF_BIT250_NS     4000
`define IMF_BIT500_NS     2000
`define IMF_BIT1000_NS    1000
`define IMF_BIT250_CYC    (`IMF_BIT250_NS / `IMF_CLK_NS)
`define IMF_BIT500_CYC    (`IMF_BIT500_NS / `IMF_CLK_NS)
`define IMF_BIT1000_CYC   (`IMF_BIT1000_NS / `IMF_CLK_NS)
`define IMF_RATE_250      2'h0
`define IMF_RATE_500      2'h1
`define IMF_RATE_1000     2'h2
`define IMF_FRQ_SCALE     64'h0000_0000_3B9A_CA00
`define IMF_RPM_SCALE     64'h0000_000D_F847_5800
`define IMF_DUTY_SCALE    32'h0000_03E8
`define IMF_RES_HI        12'hED8
`define IMF_RES_LO        12'h0C8
`define IMF_OFS_CFG       2'h0
`define IMF_OFS_LIM       2'h1
`define IMF_OFS_RES       2'h2
`define IMF_OFS_CAN       8'h70
`define IMF_CFG_RST       32'h0000_0000
`define IMF_LIM_RST       16'hFFFF
`define IMF_T_OFF         7'h00
`define IMF_T_V5          7'h0C
`define IMF_T_V10         7'h0D
`define IMF_T_I20         7'h14
`define IMF_T_I420        7'h15
`define IMF_T_RES         7'h1E
`define IMF_T_F0          7'h28
`define IMF_T_F1          7'h29
`define IMF_T_F2          7'h2A
`define IMF_T_PWM0        7'h32
`define IMF_T_PWM1        7'h33
`define IMF_T_DNRM        7'h3C
`define IMF_T_DINV        7'h3D
`define IMF_T_DLAT        7'h3E
`define IMF_T_CNT         7'h46
`define IMF_T_PC          7'h47
`define IMF_T_PC2         7'h48
`endif

// ### imf_chan.v
`include "imf_consts.vh"
`default_nettype none
module imf_chan #(
  parameter KIND      = 0,
  parameter MS_CYC    = 100000,
  parameter STALL_CYC = 400000000
) (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        pin_i,
  input  wire [6:0]  type_i,
  input  wire [1:0]  capdb_i,
  input  wire [2:0]  swdb_i,
  input  wire        pol_i,
  input  wire [7:0]  ppr_i,
  input  wire [15:0] limit_i,
  input  wire [11:0] adc_i,
  output wire [31:0] result_o,
  output wire [1:0]  isrc_o
);
localparam M_OFF = 4'h0, M_ANA = 4'h1, M_RES = 4'h2, M_FRQ = 4'h3, M_PWM = 4'h4;
localparam M_DNR = 4'h5, M_DIV = 4'h6, M_DLA = 4'h7, M_CNT = 4'h8, M_PC = 4'h9;
localparam M_PC2 = 4'hA;
localparam [31:0] CF1_CYC = `IMF_CAPF1_CYC, CF2_CYC = `IMF_CAPF2_CYC, CF3_CYC = `IMF_CAPF3_CYC;

// Kind 0 universal, 1 digital, 2 magnetic pickup
function [3:0] mode_of(input [6:0] t);
  begin
    case (t)
      `IMF_T_V5, `IMF_T_V10, `IMF_T_I20, `IMF_T_I420: mode_of = M_ANA;
      `IMF_T_RES:                                   mode_of = M_RES;
      `IMF_T_F0, `IMF_T_F1, `IMF_T_F2:              mode_of = M_FRQ;
      `IMF_T_PWM0, `IMF_T_PWM1:                     mode_of = M_PWM;
      `IMF_T_DNRM:                                  mode_of = M_DNR;
      `IMF_T_DINV:                                  mode_of = M_DIV;
      `IMF_T_DLAT:                                  mode_of = M_DLA;
      `IMF_T_CNT:                                   mode_of = M_CNT;
      `IMF_T_PC:                                    mode_of = M_PC;
      `IMF_T_PC2:                                   mode_of = M_PC2;
      default:                                      mode_of = M_OFF;
    endcase
    if (KIND == 1 && !(mode_of == M_FRQ || mode_of == M_PWM || mode_of == M_DNR ||
        mode_of == M_DIV || mode_of == M_DLA))
      mode_of = M_OFF;
    if (KIND == 2)
      mode_of = M_FRQ;
  end
endfunction

wire [3:0]  mode   = mode_of(type_i);
wire        dmode  = (mode == M_DNR) || (mode == M_DIV) || (mode == M_DLA);
reg         s1_ff, s2_ff, cf_ff, db_ff, prev_ff, lat_ff;
reg  [10:0] cf_cnt_ff;
reg  [31:0] db_cnt_ff, per_ff, hi_ff, el_ff, result_ff, pc_ff;
reg  [15:0] tmr_ff, ovf_ff;
reg  [1:0]  isrc_ff;
reg  [7:0]  settle_ff;
reg  [10:0] cf_lim;
reg  [31:0] db_lim;
reg  [31:0] nxt_result;

always @* begin
  case (capdb_i)
    2'h1:    cf_lim = CF1_CYC[10:0];
    2'h2:    cf_lim = CF2_CYC[10:0];
    2'h3:    cf_lim = CF3_CYC[10:0];
    default: cf_lim = 11'h000;
  endcase
  case (swdb_i)
    3'h1:    db_lim = 10 * MS_CYC;
    3'h2:    db_lim = 20 * MS_CYC;
    3'h3:    db_lim = 40 * MS_CYC;
    3'h4:    db_lim = 100 * MS_CYC;
    3'h5:    db_lim = 200 * MS_CYC;
    3'h6:    db_lim = 400 * MS_CYC;
    3'h7:    db_lim = 1000 * MS_CYC;
    default: db_lim = 32'h0000_0000;
  endcase
end

wire        lvl   = cf_ff ^ pol_i;
wire        sig   = dmode ? db_ff : lvl;
wire        rise  = sig & ~prev_ff;
wire        fall  = ~sig & prev_ff;
wire [31:0] now   = {ovf_ff, tmr_ff} + 32'h0000_0001;
wire [63:0] rpm_d = {32'h0000_0000, now} * {56'h0, ppr_i};
wire [63:0] frq_q = `IMF_FRQ_SCALE / {32'h0000_0000, now};
wire [63:0] rpm_q = `IMF_RPM_SCALE / rpm_d;
wire [63:0] dut_q = ({32'h0000_0000, hi_ff} * {32'h0, `IMF_DUTY_SCALE}) / {32'h0, now};
wire        stall = ({ovf_ff, tmr_ff} >= STALL_CYC);
wire        timed = (mode == M_FRQ) || (mode == M_PWM) || (mode == M_CNT);

always @* begin
  nxt_result = result_ff;
  case (mode)
    M_ANA, M_RES: nxt_result = {20'h00000, adc_i};
    M_FRQ: begin
      if (rise)
        nxt_result = (ppr_i != 8'h00) ? rpm_q[31:0] : frq_q[31:0];
      else if (stall)
        nxt_result = 32'h0000_0000;
    end
    M_PWM: begin
      if (rise)
        nxt_result = dut_q[31:0];
      else if (stall)
        nxt_result = {31'h0, sig} * `IMF_DUTY_SCALE;
    end
    M_DNR:        nxt_result = {31'h0, db_ff};
    M_DIV:        nxt_result = {31'h0, ~db_ff};
    M_DLA:        nxt_result = {31'h0, lat_ff};
    M_CNT: begin
      if (rise && pc_ff + 32'h1 >= {16'h0, limit_i})
        nxt_result = el_ff + 32'h1;
    end
    M_PC, M_PC2:  nxt_result = pc_ff;
    default:      nxt_result = 32'h0000_0000;
  endcase
end

always @(posedge clk_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    s1_ff     <= 1'b0;
    s2_ff     <= 1'b0;
    cf_ff     <= 1'b0;
    cf_cnt_ff <= 11'h000;
    db_ff     <= 1'b0;
    db_cnt_ff <= 32'h0000_0000;
    prev_ff   <= 1'b0;
    lat_ff    <= 1'b0;
    tmr_ff    <= 16'h0000;
    ovf_ff    <= 16'h0000;
    hi_ff     <= 32'h0000_0000;
    el_ff     <= 32'h0000_0000;
    pc_ff     <= 32'h0000_0000;
    result_ff <= 32'h0000_0000;
    isrc_ff   <= 2'h0;
    settle_ff <= 8'h00;
  end else begin
    s1_ff   <= pin_i;
    s2_ff   <= s1_ff;
    if (s2_ff == cf_ff)
      cf_cnt_ff <= 11'h000;
    else if (cf_cnt_ff + 11'h1 >= cf_lim) begin
      cf_ff     <= s2_ff;
      cf_cnt_ff <= 11'h000;
    end else
      cf_cnt_ff <= cf_cnt_ff + 11'h1;
    if (lvl == db_ff)
      db_cnt_ff <= 32'h0000_0000;
    else if (db_cnt_ff + 32'h1 >= db_lim) begin
      db_ff     <= lvl;
      db_cnt_ff <= 32'h0000_0000;
    end else
      db_cnt_ff <= db_cnt_ff + 32'h1;
    prev_ff   <= sig;
    result_ff <= nxt_result;
    if (mode == M_DLA && rise)
      lat_ff <= ~lat_ff;
    // 16-bit capture timer, overflow word extends it for slow inputs
    if (!timed || rise) begin
      tmr_ff <= 16'h0000;
      ovf_ff <= 16'h0000;
    end else if (!stall) begin
      tmr_ff <= tmr_ff + 16'h1;
      if (tmr_ff == 16'hFFFF)
        ovf_ff <= ovf_ff + 16'h1;
    end
    if (fall)
      hi_ff <= now;
    if (mode == M_CNT) begin
      el_ff <= el_ff + 32'h1;
      if (rise && pc_ff + 32'h1 >= {16'h0, limit_i}) begin
        pc_ff <= 32'h0000_0000;
        el_ff <= 32'h0000_0000;
      end else if (rise)
        pc_ff <= pc_ff + 32'h1;
    end else if (mode == M_PC || mode == M_PC2) begin
      if (rise || (mode == M_PC2 && fall))
        pc_ff <= (pc_ff + 32'h1 >= {16'h0, limit_i}) ? 32'h0 : pc_ff + 32'h1;
    end else begin
      pc_ff <= 32'h0000_0000;
      el_ff <= 32'h0000_0000;
    end
    // Settle time stops the source from hunting before the voltage follows
    settle_ff <= settle_ff + 8'h1;
    if (mode != M_RES)
      isrc_ff <= 2'h0;
    else if (settle_ff == 8'hFF) begin
      if (adc_i > `IMF_RES_HI && isrc_ff != 2'h0)
        isrc_ff <= isrc_ff - 2'h1;
      else if (adc_i < `IMF_RES_LO && isrc_ff != 2'h2)
        isrc_ff <= isrc_ff + 2'h1;
    end
  end
end

assign result_o = result_ff;
assign isrc_o   = isrc_ff;
endmodule // imf_chan
`default_nettype wire

// ### imf_top.v
// Operation
// - Seven inputs: four universal, two digital, one magnetic, each configured alone.
// - Digital channels only do frequency, pulse width and digital modes.
// - Universal mode follows the sensor-type code table, zero meaning disabled.
// - Digital channels refuse analog type codes twelve to twenty-one.
// - Magnetic channel measures frequency between 0.25 Hz and 20 kHz.
// - Voltage and current modes report the 12-bit converter sample.
// - Resistive mode picks 10uA, 1mA or 10mA source from measured level.
// - Frequency, PWM and counter modes use a 16-bit capture timer.
// - Two-bit capture filter: none, 111ns, 1.78us or 14.22us.
// - Digital modes add software debounce of 0 to 1000 ms by code.
// - Frequency reports tenths of RPM when pulses per revolution is set, else tenths of hertz.
// - CAN rate detection covers 250 and 500 kbit/s.
// - CAN rate detection also covers 1000 kbit/s.
// - Rate found by listening only, never transmitting, until recognised.
// - Found rate is stored; next power-up tries the stored rate first.
// - Counter mode times a set number of pulses, reports time, restarts.
// - Pulse counter counts rising edges; both-edges variant counts both.
// - Pulse count wraps to zero on reaching the maximum count.
// - Polarity zero is active high, one is active low.
`include "imf_consts.vh"
`default_nettype none
module imf_top #(
  parameter MS_CYC    = 100000,
  parameter STALL_CYC = 400000000
) (
  input  wire        clk_i,
  input  wire        rst_b_i,
  input  wire [7:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output wire [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  input  wire [3:0]  uin_pin_i,
  input  wire [1:0]  din_pin_i,
  input  wire        mag_pin_i,
  input  wire [47:0] adc_data_i,
  output wire [7:0]  res_src_o,
  input  wire        can_rx_i,
  output wire        can_tx_o,
  input  wire [1:0]  nv_rate_i,
  output wire [1:0]  nv_rate_o,
  output wire        nv_wr_o
);

////////////////////////////////////////////////////////////////////////////////
reg rs1_ff, rs2_ff;
wire rst_n = rs2_ff;
always @(posedge clk_i or negedge rst_b_i) begin
  if (!rst_b_i) begin
    rs1_ff <= 1'b0;
    rs2_ff <= 1'b0;
  end else begin
    rs1_ff <= 1'b1;
    rs2_ff <= rs1_ff;
  end
end

function [31:0] be_merge(input [31:0] old, input [31:0] wd, input [3:0] be);
  integer k;
  begin
    be_merge = old;
    for (k = 0; k < 4; k = k + 1)
      if (be[k])
        be_merge[k*8 +: 8] = wd[k*8 +: 8];
  end
endfunction

localparam [31:0] B250_CYC  = `IMF_BIT250_CYC;
localparam [31:0] B500_CYC  = `IMF_BIT500_CYC;
localparam [31:0] B1000_CYC = `IMF_BIT1000_CYC;

function [15:0] bit_cyc(input [1:0] r);
  begin
    case (r)
      `IMF_RATE_500:  bit_cyc = B500_CYC[15:0];
      `IMF_RATE_1000: bit_cyc = B1000_CYC[15:0];
      default:        bit_cyc = B250_CYC[15:0];
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
reg  [31:0] cfg_ff [0:6];
reg  [15:0] lim_ff [0:6];
wire [31:0] res_w  [0:6];
wire [1:0]  src_w  [0:6];
wire [6:0]  pins = {mag_pin_i, din_pin_i, uin_pin_i};

genvar g;
generate
  for (g = 0; g < 7; g = g + 1) begin : g_ch
    imf_chan #(
      .KIND      ((g < 4) ? 0 : ((g < 6) ? 1 : 2)),
      .MS_CYC    (MS_CYC),
      .STALL_CYC (STALL_CYC)
    ) u_chan (
      .clk_i    (clk_i),
      .rst_n_i  (rst_n),
      .pin_i    (pins[g]),
      .type_i   (cfg_ff[g][6:0]),
      .capdb_i  (cfg_ff[g][9:8]),
      .swdb_i   (cfg_ff[g][14:12]),
      .pol_i    (cfg_ff[g][16]),
      .ppr_i    (cfg_ff[g][31:24]),
      .limit_i  (lim_ff[g]),
      .adc_i    ((g < 4) ? adc_data_i[(g % 4)*12 +: 12] : 12'h000),
      .result_o (res_w[g]),
      .isrc_o   (src_w[g])
    );
    if (g < 4) begin : g_src
      assign res_src_o[g*2 +: 2] = src_w[g];
    end
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// CAN rate hunt
localparam S_INIT = 2'h0, S_HUNT = 2'h1, S_DONE = 2'h2;
reg  [1:0]  st_ff, cand_ff, rate_ff, saved_ff, nv_rate_ff;
reg         rx1_ff, rx2_ff, rxp_ff, nv_wr_ff, tx_ff, restart_ff;
reg  [15:0] ivl_ff;
reg  [4:0]  match_ff;
reg  [6:0]  seen_ff;
wire [15:0] bc   = bit_cyc(cand_ff);
wire [15:0] tol  = {3'h0, bc[15:3]};
wire        edg  = rx2_ff ^ rxp_ff;
// First edge after a (re)start only opens an interval; the time before it is no bit
wire        armed = (seen_ff != 7'h00);
wire        shrt = ivl_ff < bc - tol;
wire        hit  = armed && (ivl_ff >= bc - tol) && (ivl_ff <= bc + tol);
wire        fail = edg && armed && (shrt || seen_ff == 7'h3F);
wire [1:0]  nxt_cand = (cand_ff == `IMF_RATE_1000) ? `IMF_RATE_250 : cand_ff + 2'h1;

always @(posedge clk_i or negedge rst_n) begin
  if (!rst_n) begin
    st_ff      <= S_INIT;
    cand_ff    <= `IMF_RATE_250;
    rate_ff    <= `IMF_RATE_250;
    saved_ff   <= `IMF_RATE_250;
    nv_rate_ff <= `IMF_RATE_250;
    nv_wr_ff   <= 1'b0;
    tx_ff      <= 1'b1;
    rx1_ff     <= 1'b1;
    rx2_ff     <= 1'b1;
    rxp_ff     <= 1'b1;
    ivl_ff     <= 16'h0000;
    match_ff   <= 5'h00;
    seen_ff    <= 7'h00;
  end else begin
    rx1_ff   <= can_rx_i;
    rx2_ff   <= rx1_ff;
    rxp_ff   <= rx2_ff;
    nv_wr_ff <= 1'b0;
    tx_ff    <= 1'b1;
    ivl_ff   <= edg ? 16'h0000 : ((ivl_ff == 16'hFFFF) ? ivl_ff : ivl_ff + 16'h1);
    case (st_ff)
      S_INIT: begin
        // Stored rate caught after reset release, then tried first
        saved_ff <= (nv_rate_i > `IMF_RATE_1000) ? `IMF_RATE_250 : nv_rate_i;
        cand_ff  <= (nv_rate_i > `IMF_RATE_1000) ? `IMF_RATE_250 : nv_rate_i;
        st_ff    <= S_HUNT;
      end
      S_HUNT: begin
        if (fail) begin
          cand_ff  <= nxt_cand;
          match_ff <= 5'h00;
          seen_ff  <= 7'h00;
        end else if (edg) begin
          seen_ff <= seen_ff + 7'h1;
          if (hit && match_ff == 5'h0F) begin
            rate_ff <= cand_ff;
            st_ff   <= S_DONE;
            if (cand_ff != saved_ff) begin
              nv_rate_ff <= cand_ff;
              nv_wr_ff   <= 1'b1;
              saved_ff   <= cand_ff;
            end
          end else if (hit)
            match_ff <= match_ff + 5'h1;
        end
      end
      S_DONE: begin
        if (restart_ff) begin
          cand_ff  <= rate_ff;
          match_ff <= 5'h00;
          seen_ff  <= 7'h00;
          st_ff    <= S_HUNT;
        end
      end
      default: st_ff <= S_INIT;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// Avalon slave: every access answers in the cycle after it is seen
reg         wait_ff;
reg  [31:0] rd_ff;
wire        req  = (avs_read_i | avs_write_i) & wait_ff;
wire [3:0]  ch   = avs_address_i[7:4];
wire [1:0]  ofs  = avs_address_i[3:2];
wire        chok = (ch < 4'h7);
wire [31:0] lim_new = be_merge({16'h0, lim_ff[ch[2:0]]}, avs_writedata_i,
                               avs_byteenable_i);
integer     i;

always @(posedge clk_i or negedge rst_n) begin
  if (!rst_n) begin
    wait_ff    <= 1'b1;
    rd_ff      <= 32'h0000_0000;
    restart_ff <= 1'b0;
    for (i = 0; i < 7; i = i + 1) begin
      cfg_ff[i] <= `IMF_CFG_RST;
      lim_ff[i] <= `IMF_LIM_RST;
    end
  end else begin
    wait_ff    <= ~req;
    restart_ff <= 1'b0;
    if (req && avs_read_i) begin
      rd_ff <= 32'h0000_0000;
      if (avs_address_i == `IMF_OFS_CAN)
        rd_ff <= {26'h0, st_ff == S_HUNT, st_ff == S_DONE, 2'h0, rate_ff};
      else if (chok && ofs == `IMF_OFS_CFG)
        rd_ff <= cfg_ff[ch[2:0]] & 32'hFF01_737F;
      else if (chok && ofs == `IMF_OFS_LIM)
        rd_ff <= {16'h0000, lim_ff[ch[2:0]]};
      else if (chok && ofs == `IMF_OFS_RES)
        rd_ff <= res_w[ch[2:0]];
    end
    if (!wait_ff && avs_write_i) begin
      if (avs_address_i == `IMF_OFS_CAN)
        restart_ff <= avs_byteenable_i[0] & avs_writedata_i[0];
      else if (chok && ofs == `IMF_OFS_CFG)
        cfg_ff[ch[2:0]] <= be_merge(cfg_ff[ch[2:0]], avs_writedata_i, avs_byteenable_i);
      else if (chok && ofs == `IMF_OFS_LIM)
        lim_ff[ch[2:0]] <= lim_new[15:0];
    end
  end
end

assign avs_readdata_o    = rd_ff;
assign avs_waitrequest_o = wait_ff;
assign can_tx_o          = tx_ff;
assign nv_rate_o         = nv_rate_ff;
assign nv_wr_o           = nv_wr_ff;
endmodule // imf_top
`default_nettype wire

// ### imf_pad_unused.v
`default_nettype none
`default_nettype wire

// ### imf_chk_assertions.sv
`default_nettype none
module imf_chk #(
  parameter MS_CYC    = 100000,
  parameter STALL_CYC = 400000000
) (
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [7:0]  res_src_o,
  input wire logic        can_tx_o,
  input wire logic [1:0]  nv_rate_o,
  input wire logic        nv_wr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  //////////////////////////////////////////////////////////////////////////////
  chk_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("bus request not answered next cycle");
  chk_bus_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  chk_bus_cause: assert property ($fell(avs_waitrequest_o)
    |-> $past(avs_read_i) || $past(avs_write_i)) else $error("answer without request");
  // Read data may only move with a read answer, never on a write
  chk_read_hold: assert property (!$stable(avs_readdata_o)
    |-> $fell(avs_waitrequest_o) && $past(avs_read_i)) else $error("read data moved");
  chk_tx_recessive: assert property (can_tx_o)
    else $error("transmit line driven dominant");
  chk_source_code: assert property (res_src_o[1:0] != 2'h3 && res_src_o[3:2] != 2'h3
    && res_src_o[5:4] != 2'h3 && res_src_o[7:6] != 2'h3) else $error("bad source code");
  chk_store_pulse: assert property (nv_wr_o |=> !nv_wr_o)
    else $error("store strobe longer than one cycle");
  chk_store_rate: assert property (nv_wr_o |-> nv_rate_o != 2'h3)
    else $error("stored rate code illegal");
endmodule // imf_chk
bind imf_top imf_chk #(.MS_CYC(MS_CYC), .STALL_CYC(STALL_CYC)) imf_chk_inst (
  .clk_i, .rst_b_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
  .res_src_o, .can_tx_o, .nv_rate_o, .nv_wr_o);
`default_nettype wire

// ### imf_sensor_model.sv
`default_nettype none
module imf_sensor_model (
  input  wire logic        clk_i,
  input  wire logic [6:0]  lvl_i,
  input  wire logic [6:0]  run_i,
  input  wire logic [15:0] half_i,
  input  wire logic [15:0] can_half_i,
  output logic      [6:0]  pin_o,
  output logic             can_rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_ff;
  logic [15:0] can_cnt_ff;
  logic        wave_ff;
  logic        can_ff;
  initial begin
    cnt_ff = 16'h0;
    can_cnt_ff = 16'h0;
    wave_ff = 1'b0;
    can_ff = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////////
  // One shared square wave keeps every running pin at an exact, known period
  always @(posedge clk_i) begin
    cnt_ff <= (cnt_ff + 16'h1 >= half_i) ? 16'h0 : cnt_ff + 16'h1;
    if (cnt_ff + 16'h1 >= half_i)
      wave_ff <= ~wave_ff;
    can_cnt_ff <= (can_cnt_ff + 16'h1 >= can_half_i) ? 16'h0 : can_cnt_ff + 16'h1;
    // A silent bus rests recessive instead of toggling
    if (can_half_i == 16'h0)
      can_ff <= 1'b1;
    else if (can_cnt_ff + 16'h1 >= can_half_i)
      can_ff <= ~can_ff;
  end
  assign pin_o = lvl_i ^ (run_i & {7{wave_ff}});
  assign can_rx_o = can_ff;
endmodule // imf_sensor_model
`default_nettype wire

// ### tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] ANA [4] = '{7'h0C, 7'h14, 7'h15, 7'h1E};
  logic        clk_i;
  logic        rst_b_i;
  logic [7:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  wire  [31:0] avs_readdata_o;
  wire         avs_waitrequest_o;
  logic [6:0]  lvl;
  logic [6:0]  run;
  logic [15:0] half;
  logic [15:0] can_half;
  wire  [6:0]  pin;
  wire         can_rx;
  logic [47:0] adc;
  wire  [7:0]  res_src;
  wire         can_tx;
  logic [1:0]  nv_rate_i;
  wire  [1:0]  nv_rate_o;
  wire         nv_wr;
  logic [31:0] rdata;
  logic [1:0]  wr_rate;
  int          wr_seen;
  int          bad_count;
  int          check_count;
  //////////////////////////////////////////////////////////////////////////////
  imf_top #(.MS_CYC(10), .STALL_CYC(8000)) imf_top_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .uin_pin_i(pin[3:0]), .din_pin_i(pin[5:4]),
    .mag_pin_i(pin[6]), .adc_data_i(adc), .res_src_o(res_src), .can_rx_i(can_rx),
    .can_tx_o(can_tx), .nv_rate_i(nv_rate_i), .nv_rate_o(nv_rate_o), .nv_wr_o(nv_wr));
  imf_sensor_model imf_sensor_model_inst (
    .clk_i(clk_i), .lvl_i(lvl), .run_i(run), .half_i(half), .can_half_i(can_half),
    .pin_o(pin), .can_rx_o(can_rx));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (nv_wr === 1'b1) begin
      wr_seen <= wr_seen + 1;
      wr_rate <= nv_rate_o;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic expect_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // Request held from just after an edge until the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) begin
      n++;
      if (n > 50) begin
        $display("unexpected bus wait: expected answer seen none");
        bad_count++;
        give_verdict();
      end
      @(posedge clk_i);
    end
    rdata = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    expect_val(what, exp, rdata);
  endtask
  // Raw level goes high; result must stay 0 for t1 cycles and be 1 after t2 more
  task automatic db_chk(input int ch, input logic [31:0] cfg, input int t1, input int t2);
    bus(1'b1, 8'(ch * 16), cfg);
    lvl[ch] <= 1'b1;
    repeat (t1) @(posedge clk_i);
    rd_chk(8'(ch * 16 + 8), 32'h0, "debounce early");
    repeat (t2) @(posedge clk_i);
    rd_chk(8'(ch * 16 + 8), 32'h1, "debounce late");
  endtask
  task automatic pulses(input int ch, input int n);
    repeat (n) begin
      lvl[ch] <= 1'b1;
      repeat (20) @(posedge clk_i);
      lvl[ch] <= 1'b0;
      repeat (20) @(posedge clk_i);
    end
  endtask
  task automatic wait_lock;
    int n;
    n = 0;
    rdata = 32'h0;
    while (rdata[4] !== 1'b1) begin
      n++;
      if (n > 15000) begin
        $display("unexpected lock wait: expected lock seen none");
        bad_count++;
        give_verdict();
      end
      bus(1'b0, 8'h70, 32'h0);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b_i = 1'b0;
    avs_address_i = 8'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    lvl = 7'h00;
    run = 7'h00;
    half = 16'h09C4;
    can_half = 16'h00C8;
    adc = 48'h123_456_789_ABC;
    nv_rate_i = 2'h1;
    wr_seen = 0;
    bad_count = 0;
    check_count = 0;
    repeat (5) @(posedge clk_i);
    expect_val("reset outputs", 32'h600, {21'h0, avs_waitrequest_o, can_tx, nv_wr, res_src});
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd_chk(8'h00, 32'h0, "cfg reset");
    rd_chk(8'h24, 32'h0000_FFFF, "limit reset");
    bus(1'b1, 8'h74, 32'hFFFF_FFFF);
    rd_chk(8'h74, 32'h0, "unmapped");
    rd_chk(8'h0C, 32'h0, "unmapped");
    for (int i = 0; i < 4; i++)
      bus(1'b1, 8'(i * 16), {25'h0, ANA[i]});
    repeat (10) @(posedge clk_i);
    for (int i = 0; i < 4; i++)
      rd_chk(8'(i * 16 + 8), {20'h0, adc[i*12 +: 12]}, "sample");
    adc[47:36] <= 12'h010;
    repeat (1000) @(posedge clk_i);
    expect_val("source", 32'h2, {30'h0, res_src[7:6]});
    adc[47:36] <= 12'hFFF;
    repeat (1000) @(posedge clk_i);
    expect_val("source", 32'h0, {30'h0, res_src[7:6]});
    adc[47:36] <= 12'h010;
    repeat (1000) @(posedge clk_i);
    bus(1'b1, 8'h30, 32'h0);
    repeat (5) @(posedge clk_i);
    rd_chk(8'h38, 32'h0, "disabled");
    expect_val("source", 32'h0, {24'h0, res_src});
    db_chk(4, 32'h0000_103C, 50, 150);
    db_chk(5, 32'h0000_403C, 900, 300);
    db_chk(1, 32'h0000_703C, 9000, 2000);
    db_chk(0, 32'h0000_033C, 1000, 800);
    bus(1'b1, 8'h40, 32'h0001_003C);
    repeat (10) @(posedge clk_i);
    rd_chk(8'h48, 32'h0, "active low");
    bus(1'b1, 8'h50, 32'h0000_000C);
    repeat (10) @(posedge clk_i);
    rd_chk(8'h58, 32'h0, "analog on digital");
    bus(1'b1, 8'h00, 32'h0000_0028);
    run <= 7'h41;
    repeat (12000) @(posedge clk_i);
    rd_chk(8'h08, 32'h0003_0D40, "hertz");
    rd_chk(8'h68, 32'h0003_0D40, "hertz");
    bus(1'b1, 8'h60, 32'h0200_0000);
    bus(1'b1, 8'h00, 32'h0000_0032);
    repeat (11000) @(posedge clk_i);
    rd_chk(8'h68, 32'h005B_8D80, "rpm");
    rd_chk(8'h08, 32'h0000_01F4, "duty");
    run <= 7'h00;
    repeat (10000) @(posedge clk_i);
    rd_chk(8'h68, 32'h0, "stalled");
    bus(1'b1, 8'h34, 32'h0000_0005);
    bus(1'b1, 8'h30, 32'h0000_0047);
    pulses(3, 3);
    rd_chk(8'h38, 32'h3, "rising count");
    pulses(3, 3);
    rd_chk(8'h38, 32'h1, "wrapped count");
    bus(1'b1, 8'h30, 32'h0000_0046);
    pulses(3, 11);
    rd_chk(8'h38, 32'h0000_00C8, "window time");
    bus(1'b1, 8'h30, 32'h0000_003E);
    pulses(3, 3);
    rd_chk(8'h38, 32'h1, "latched");
    bus(1'b1, 8'h20, 32'h0000_0048);
    pulses(2, 2);
    rd_chk(8'h28, 32'h4, "edge count");
    wait_lock();
    expect_val("rate", 32'h11, {26'h0, rdata[5:0]});
    expect_val("stores", 32'h0, 32'(wr_seen));
    can_half <= 16'h0064;
    bus(1'b1, 8'h70, 32'h1);
    wait_lock();
    expect_val("rate", 32'h12, {26'h0, rdata[5:0]});
    expect_val("stored", 32'h2, {30'h0, wr_rate});
    can_half <= 16'h0190;
    bus(1'b1, 8'h70, 32'h1);
    wait_lock();
    expect_val("rate", 32'h10, {26'h0, rdata[5:0]});
    expect_val("stored", 32'h0, {30'h0, wr_rate});
    expect_val("stores", 32'h2, 32'(wr_seen));
    give_verdict();
  end
endmodule // tb
`default_nettype wire
